// >>> src/sbsr_flag.sv
// Sticky flag with set priority over clear
`timescale 1ns/100ps
`default_nettype none
module sbsr_flag
  import sbsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  logic next_flag;

  always_comb
  begin
    next_flag = flag;
    if (clear)
      next_flag = 1'b0;
    if (set)
      next_flag = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end
endmodule
`default_nettype wire

// >>> src/sbsr_pkg.sv
// Package for the status byte and service request block
package sbsr_pkg;
  // ----------------------------------------
  // Status byte field positions
  // ----------------------------------------
  localparam int SBSR_BIT_STATE = 0;
  localparam int SBSR_BIT_ADAPT = 2;
  localparam int SBSR_BIT_MAV = 4;
  localparam int SBSR_BIT_ESB = 5;
  localparam int SBSR_BIT_SUM = 6;
  localparam logic [7:0] SBSR_RSVD_MASK = 8'h8a;
  localparam logic [7:0] SBSR_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SBSR_STATUS_RESET = 8'h00;
  localparam logic [7:0] SBSR_ENABLE_WMASK = 8'hbf;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic std_event_enabled;
    logic queue_not_empty;
    logic value_adapted;
    logic state_enabled;
  } sbsr_events_t;

  typedef struct packed {
    logic query_read;
    logic poll_read;
    logic esr_clear;
    logic clear_all;
  } sbsr_access_t;

  typedef enum logic [1:0] {
    SBSR_IDLE = 2'b00,
    SBSR_REQUEST = 2'b01,
    SBSR_REPORTED = 2'b11
  } sbsr_state_t;
endpackage

// >>> src/sbsr_top.sv
// Status byte summary and service request logic
`timescale 1ns/100ps
`default_nettype none
module sbsr_top
  import sbsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire sbsr_events_t events,
  input wire sbsr_access_t access,
  input wire logic enable_write,
  input wire logic [7:0] enable_wdata,
  output logic [7:0] enable_rdata,
  output logic [7:0] status_summary_byte,
  output logic [7:0] poll_byte,
  output logic service_request
);
  // ----------------------------------------
  // Sticky summary flags and the live message-available bit
  // ----------------------------------------
  logic esb;
  logic value_adapted_flag;
  logic internal_state_flag;
  logic mav;
  logic [7:0] enable_mask;
  logic [7:0] next_enable_mask;
  logic [7:0] summary_bits;
  logic mss;
  logic rqs;

  sbsr_flag u_esb
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(events.std_event_enabled),
    .clear(access.esr_clear | access.clear_all),
    .flag(esb)
  );

  sbsr_flag u_value_adapted
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(events.value_adapted),
    .clear(access.clear_all),
    .flag(value_adapted_flag)
  );

  sbsr_flag u_internal_state
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .set(events.state_enabled),
    .clear(access.clear_all),
    .flag(internal_state_flag)
  );

  assign mav = events.queue_not_empty;

  // ----------------------------------------
  // Summary byte and enable mask
  // ----------------------------------------
  always_comb
  begin
    summary_bits = 8'h00;
    summary_bits[SBSR_BIT_STATE] = internal_state_flag;
    summary_bits[SBSR_BIT_ADAPT] = value_adapted_flag;
    summary_bits[SBSR_BIT_MAV] = mav;
    summary_bits[SBSR_BIT_ESB] = esb;
  end

  assign mss = |(summary_bits & enable_mask);

  always_comb
  begin
    next_enable_mask = enable_mask;
    if (enable_write)
      next_enable_mask = enable_wdata & SBSR_ENABLE_WMASK;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      enable_mask <= SBSR_ENABLE_RESET;
    else
      enable_mask <= next_enable_mask;
  end

  // ----------------------------------------
  // Request-service state
  // ----------------------------------------
  sbsr_state_t state;
  sbsr_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SBSR_IDLE:
        if (mss)
          next_state = SBSR_REQUEST;
      SBSR_REQUEST:
        if (access.poll_read)
          next_state = SBSR_REPORTED;
        else if (!mss)
          next_state = SBSR_IDLE;
      SBSR_REPORTED:
        if (!mss)
          next_state = SBSR_IDLE;
      default:
        next_state = SBSR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state <= SBSR_IDLE;
    else
      state <= next_state;
  end

  assign rqs = (state == SBSR_REQUEST);

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic [7:0] next_status;
  logic [7:0] next_poll;
  logic [7:0] next_enable_rd;

  always_comb
  begin
    next_status = status_summary_byte;
    next_poll = poll_byte;
    next_enable_rd = enable_mask;
    if (access.query_read)
    begin
      next_status = summary_bits & ~SBSR_RSVD_MASK;
      next_status[SBSR_BIT_SUM] = mss;
    end
    if (access.poll_read)
    begin
      next_poll = summary_bits & ~SBSR_RSVD_MASK;
      next_poll[SBSR_BIT_SUM] = rqs;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      status_summary_byte <= SBSR_STATUS_RESET;
      poll_byte <= SBSR_STATUS_RESET;
      enable_rdata <= SBSR_ENABLE_RESET;
      service_request <= 1'b0;
    end
    else
    begin
      status_summary_byte <= next_status;
      poll_byte <= next_poll;
      enable_rdata <= next_enable_rd;
      service_request <= mss;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_query_summary: assert property (
    @(posedge sys_clk) disable iff (reset)
    access.query_read |=> status_summary_byte[SBSR_BIT_SUM] == $past(mss))
    else $error("query byte bit 6 not summary");
  chk_poll_request: assert property (
    @(posedge sys_clk) disable iff (reset)
    access.poll_read |=> poll_byte[SBSR_BIT_SUM] == $past(rqs))
    else $error("poll byte bit 6 not request");
  chk_summary_mask: assert property (
    @(posedge sys_clk) disable iff (reset)
    access.query_read |=> status_summary_byte[SBSR_BIT_SUM] ==
      |(status_summary_byte & $past(enable_mask)))
    else $error("summary mismatch");
  chk_esb_sets: assert property (
    @(posedge sys_clk) disable iff (reset)
    events.std_event_enabled |=> esb)
    else $error("event summary not set");
  chk_mav_follow: assert property (
    @(posedge sys_clk) disable iff (reset)
    access.query_read |=> status_summary_byte[SBSR_BIT_MAV] ==
      $past(events.queue_not_empty))
    else $error("message available wrong");
  chk_adapted_sets: assert property (
    @(posedge sys_clk) disable iff (reset)
    events.value_adapted |=> value_adapted_flag)
    else $error("value adapted not set");
  chk_state_sets: assert property (
    @(posedge sys_clk) disable iff (reset)
    events.state_enabled |=> internal_state_flag)
    else $error("internal state not set");
  chk_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (reset)
    (status_summary_byte & SBSR_RSVD_MASK) == 8'h00 &&
      (poll_byte & SBSR_RSVD_MASK) == 8'h00)
    else $error("reserved bits set");
  chk_mask_bit6: assert property (
    @(posedge sys_clk) disable iff (reset)
    enable_write ##1 !enable_write |=>
      enable_rdata == ($past(enable_wdata, 2) & SBSR_ENABLE_WMASK))
    else $error("enable mask readback wrong");
  chk_srq_follow: assert property (
    @(posedge sys_clk) disable iff (reset)
    service_request == $past(mss))
    else $error("service request missing");
  chk_rqs_cleared: assert property (
    @(posedge sys_clk) disable iff (reset)
    (rqs && access.poll_read) |=> !rqs)
    else $error("request not cleared by poll");

  cov_poll_request: cover property (@(posedge sys_clk) disable iff (reset)
    rqs && access.poll_read);
  cov_query_read: cover property (@(posedge sys_clk) disable iff (reset)
    access.query_read && mss);
  cov_set_clear: cover property (@(posedge sys_clk) disable iff (reset)
    events.std_event_enabled && access.esr_clear);
endmodule
`default_nettype wire

// >>> test/sbsr_host.sv
// Remote controller model: strobes reads, clears and enable-mask writes
`timescale 1ns/100ps
`default_nettype none
module sbsr_host
  import sbsr_pkg::*;
(
  input wire logic sys_clk,
  output var sbsr_access_t access,
  output var logic enable_write,
  output var logic [7:0] enable_wdata
);
  initial
  begin
    access = '0;
    enable_write = 1'b0;
    enable_wdata = 8'h00;
  end
  task automatic strobe(input sbsr_access_t a);
    @(posedge sys_clk);
    access <= a;
    @(posedge sys_clk);
    access <= '0;
  endtask
  // Released data shows the inverse, never the last value
  task automatic write_mask(input logic [7:0] m);
    @(posedge sys_clk);
    enable_write <= 1'b1;
    enable_wdata <= m;
    @(posedge sys_clk);
    enable_write <= 1'b0;
    enable_wdata <= ~m;
  endtask
endmodule
`default_nettype wire

// >>> test/status_byte_service_request_tb.sv
// Self-checking bench for the status byte and service request block
`timescale 1ns/100ps
`default_nettype none
module status_byte_service_request_tb;
  import sbsr_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  sbsr_events_t ev = '0;
  sbsr_access_t acc;
  logic en_w;
  logic [7:0] en_d, en_r, query_byte, pol;
  logic srq;
  int bad_count = 0;
  int comparisons = 0;
  integer seed = 32'hed24dd10;
  logic [7:0] mask = 8'h00;
  logic [7:0] stat = 8'h00;
  logic polled = 1'b0;
  logic [31:0] r;
  sbsr_host sbsr_host_i (.sys_clk(sys_clk), .access(acc),
    .enable_write(en_w), .enable_wdata(en_d));
  sbsr_top sbsr_top_i (.sys_clk(sys_clk), .reset(reset), .events(ev),
    .access(acc), .enable_write(en_w), .enable_wdata(en_d),
    .enable_rdata(en_r), .status_summary_byte(query_byte), .poll_byte(pol),
    .service_request(srq));
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic cmp8(input string w, input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, w, g, e);
    end
  endtask
  // RQS re-arms once the summary has dropped
  task automatic upd;
    if (!(|(stat & mask)))
      polled = 1'b0;
  endtask
  task automatic fire(input sbsr_events_t e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= e & 4'b0100;
    // Queue level lands one cycle before the flags: summary may dip
    stat[4] = e[2];
    upd;
    stat = {2'b00, stat[5] | e[3], e[2], 1'b0, stat[2] | e[1], 1'b0,
      stat[0] | e[0]};
    upd;
  endtask
  task automatic clr(input sbsr_access_t a);
    sbsr_host_i.strobe(a);
    stat[5] = 1'b0;
    if (a[0])
      stat = stat & 8'h10;
    upd;
  endtask
  task automatic wmask(input logic [7:0] m);
    sbsr_host_i.write_mask(m);
    mask = m & 8'hbf;
    upd;
  endtask
  task automatic check_all;
    logic m;
    repeat (3) @(posedge sys_clk);
    m = |(stat & mask);
    sbsr_host_i.strobe(4'b1000);
    @(negedge sys_clk);
    cmp8("query", query_byte, stat | {1'b0, m, 6'h00});
    sbsr_host_i.strobe(4'b0100);
    @(negedge sys_clk);
    cmp8("poll", pol, stat | {1'b0, m & !polled, 6'h00});
    polled = polled | m;
    cmp8("srq", {7'h00, srq}, {7'h00, m});
    cmp8("mask", en_r, mask);
  endtask
  task automatic complete_run;
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    check_all;
    wmask(8'h11);
    fire(4'b0100);
    check_all;
    check_all;
    wmask(8'hff);
    check_all;
    $display("directed test done");
    repeat (300)
    begin
      r = $random(seed);
      fire(r[3:0]);
      if (r[4])
        clr(r[5] ? 4'b0001 : 4'b0010);
      if (r[6])
        wmask(r[15:8]);
      check_all;
    end
    $display("random test done");
    complete_run;
  end
endmodule
`default_nettype wire
